//--- shared/iovp_pkg.sv
// Constants and carrier types for the input overvoltage protection registers
`default_nettype none
package iovp_pkg;
  // Register offsets
  localparam logic [7:0] IOVP_OFS_INPUT_FET_PROTECTION = 8'h05;
  localparam logic [7:0] IOVP_OFS_BUS_OVERVOLTAGE_CONFIG = 8'h06;
  // Reset values
  localparam logic [7:0] IOVP_RST_INPUT_FET_PROTECTION = 8'h03;
  localparam logic [7:0] IOVP_RST_BUS_OVERVOLTAGE_CONFIG = 8'h3a;
  // Field positions, first register
  localparam int IOVP_POS_LIVE_STATUS = 7;
  localparam int IOVP_POS_EVENT_FLAG = 6;
  localparam int IOVP_POS_IRQ_MASK = 5;
  localparam int IOVP_POS_RSVD_HI = 4;
  localparam int IOVP_POS_RSVD_LO = 3;
  localparam int IOVP_POS_EXT_THR_HI = 2;
  localparam int IOVP_POS_EXT_THR_LO = 0;
  // Field positions, second register
  localparam int IOVP_POS_PULLDOWN_EN = 7;
  localparam int IOVP_POS_BUS_THR_HI = 6;
  localparam int IOVP_POS_BUS_THR_LO = 0;
  // Reserved bits read back as this constant
  localparam logic [1:0] IOVP_RSVD_READ = 2'h0;
  // Threshold arithmetic, in mV except the all ones code
  localparam logic [15:0] IOVP_EXT_BASE_MV = 16'h2af8;
  localparam logic [15:0] IOVP_EXT_STEP_MV = 16'h03e8;
  localparam logic [15:0] IOVP_EXT_SPECIAL_MV = 16'h1964;
  localparam logic [2:0] IOVP_EXT_SPECIAL_CODE = 3'h7;
  localparam logic [15:0] IOVP_BUS_BASE_MV = 16'h173e;
  localparam logic [15:0] IOVP_BUS_STEP_MV = 16'h0032;

  // Register access request from the serial control bus front end
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iovp_reg_req_t;

  // Protection actions driven to the power stage
  typedef struct packed {
    logic external_fet_gate_drive;
    logic bus_pulldown;
    logic blocking_switch;
    logic charge_enable_force_off;
  } iovp_power_ctl_t;
endpackage
`default_nettype wire

//--- core/iovp_regs.sv
// Input overvoltage protection register pair and its protection actions
//
// Contract
// - Bit 7 of the first register reads high while the input overvoltage exists, low after.
// - Bit 6 latches an input overvoltage event and clears when the first register is read.
// - With mask bit 5 set no interrupt is raised for the event, but the flag still records it.
// - The input threshold is 11 V plus the 3-bit code in bits 2 to 0 times 1 V.
// - Code all ones selects a 6.5 V input threshold instead of the formula.
// - Bus voltage at or above the input threshold turns the external FET gate drive off.
// - Bit 7 of the second register enables the bus pulldown and turns the external FET off.
// - The pulldown is active whenever the external FET charge pump is not running.
// - The bus threshold is 5.95 V plus bits 6 to 0 times 50 mV, reset code gives 8.85 V.
// - Bus voltage at the bus threshold opens the blocking switch and forces charge enable off.
`default_nettype none
module iovp_regs (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register soft reset pulse
  input wire logic reg_soft_rst_i,
  // Register access
  input wire iovp_pkg::iovp_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Measured bus supply node voltage, mV, same clock
  input wire logic [15:0] bus_supply_node_mv_i,
  // Charge pump running indication, asynchronous pin
  input wire logic charge_pump_running_i,
  // Host interrupt line
  output logic irq_o,
  // Power stage control
  output iovp_pkg::iovp_power_ctl_t power_ctl_o,
  // Programmed thresholds in mV
  output logic [15:0] external_input_ovp_threshold_mv_o,
  output logic [15:0] bus_overvoltage_threshold_mv_o
);
  import iovp_pkg::*;

  // Stored fields
  logic input_ovp_event_flag;
  logic input_ovp_irq_mask;
  logic [2:0] external_input_ovp_threshold;
  logic bus_pulldown_enable;
  logic [6:0] bus_overvoltage_threshold;
  // Live conditions, registered from the measurement, and the previous live status
  logic input_ovp_live_status;
  logic bus_overvoltage_config_live;
  logic prev_input_ovp;
  // Charge pump synchroniser
  logic cp_meta;
  logic cp_sync;
  // Read data
  logic [7:0] rdata;
  logic rvalid;

  // Decode
  wire sel_fet = reg_req_i.addr == IOVP_OFS_INPUT_FET_PROTECTION;
  wire sel_bus = reg_req_i.addr == IOVP_OFS_BUS_OVERVOLTAGE_CONFIG;
  wire wr_fet = reg_req_i.wr && sel_fet;
  wire wr_bus = reg_req_i.wr && sel_bus;
  wire rd_fet = reg_req_i.rd && sel_fet;
  wire rd_bus = reg_req_i.rd && sel_bus;
  // Write data fields, named for the checks
  wire [2:0] wdata_ext_thr = reg_req_i.wdata[IOVP_POS_EXT_THR_HI:IOVP_POS_EXT_THR_LO];
  wire wdata_irq_mask = reg_req_i.wdata[IOVP_POS_IRQ_MASK];
  wire wdata_pd_en = reg_req_i.wdata[IOVP_POS_PULLDOWN_EN];
  wire [6:0] wdata_bus_thr = reg_req_i.wdata[IOVP_POS_BUS_THR_HI:IOVP_POS_BUS_THR_LO];

  // Threshold arithmetic
  wire ext_special = external_input_ovp_threshold == IOVP_EXT_SPECIAL_CODE;
  wire [15:0] ext_linear_mv = 16'(IOVP_EXT_BASE_MV
      + 16'(external_input_ovp_threshold) * IOVP_EXT_STEP_MV);
  wire [15:0] ext_thr_mv = ext_special ? IOVP_EXT_SPECIAL_MV : ext_linear_mv;
  // Base kept exact, so the reset code lands at 8.85 V
  wire [15:0] bus_thr_mv = 16'(IOVP_BUS_BASE_MV
      + 16'(bus_overvoltage_threshold) * IOVP_BUS_STEP_MV);

  // Comparisons against the measured node
  wire next_input_ovp = bus_supply_node_mv_i >= ext_thr_mv;
  wire next_bus_overvoltage_config = bus_supply_node_mv_i >= bus_thr_mv;
  // Event is the rising edge of the live condition
  wire input_ovp_event = input_ovp_live_status && !prev_input_ovp;

  // Read images
  wire [7:0] fet_image = {input_ovp_live_status, input_ovp_event_flag, input_ovp_irq_mask,
                          IOVP_RSVD_READ, external_input_ovp_threshold};
  wire [7:0] bus_image = {bus_pulldown_enable, bus_overvoltage_threshold};
  wire [7:0] next_rdata = rd_fet ? fet_image : (rd_bus ? bus_image : 8'h00);

  // Flag: set beats read clear so a coincident event is kept
  wire next_flag = input_ovp_event ? 1'b1 : (rd_fet ? 1'b0 : input_ovp_event_flag);

  // Live status and edge history
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      input_ovp_live_status <= 1'b0;
      bus_overvoltage_config_live <= 1'b0;
      prev_input_ovp <= 1'b0;
    end else begin
      input_ovp_live_status <= next_input_ovp;
      bus_overvoltage_config_live <= next_bus_overvoltage_config;
      prev_input_ovp <= input_ovp_live_status;
    end
  end

  // Charge pump pin, two stages before any use
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cp_meta <= 1'b0;
      cp_sync <= 1'b0;
    end else begin
      cp_meta <= charge_pump_running_i;
      cp_sync <= cp_meta;
    end
  end

  // Event flag
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      input_ovp_event_flag <= 1'b0;
    end else if (reg_soft_rst_i) begin
      input_ovp_event_flag <= 1'b0;
    end else begin
      input_ovp_event_flag <= next_flag;
    end
  end

  // Writable fields; no watchdog input since it touches none of them
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      input_ovp_irq_mask <= IOVP_RST_INPUT_FET_PROTECTION[IOVP_POS_IRQ_MASK];
      external_input_ovp_threshold <=
          IOVP_RST_INPUT_FET_PROTECTION[IOVP_POS_EXT_THR_HI:IOVP_POS_EXT_THR_LO];
      bus_pulldown_enable <= IOVP_RST_BUS_OVERVOLTAGE_CONFIG[IOVP_POS_PULLDOWN_EN];
      bus_overvoltage_threshold <=
          IOVP_RST_BUS_OVERVOLTAGE_CONFIG[IOVP_POS_BUS_THR_HI:IOVP_POS_BUS_THR_LO];
    end else if (reg_soft_rst_i) begin
      input_ovp_irq_mask <= IOVP_RST_INPUT_FET_PROTECTION[IOVP_POS_IRQ_MASK];
      external_input_ovp_threshold <=
          IOVP_RST_INPUT_FET_PROTECTION[IOVP_POS_EXT_THR_HI:IOVP_POS_EXT_THR_LO];
      bus_pulldown_enable <= IOVP_RST_BUS_OVERVOLTAGE_CONFIG[IOVP_POS_PULLDOWN_EN];
      bus_overvoltage_threshold <=
          IOVP_RST_BUS_OVERVOLTAGE_CONFIG[IOVP_POS_BUS_THR_HI:IOVP_POS_BUS_THR_LO];
    end else begin
      if (wr_fet) begin
        // Status, flag and reserved bits are not writable
        input_ovp_irq_mask <= reg_req_i.wdata[IOVP_POS_IRQ_MASK];
        external_input_ovp_threshold <=
            reg_req_i.wdata[IOVP_POS_EXT_THR_HI:IOVP_POS_EXT_THR_LO];
      end
      if (wr_bus) begin
        bus_pulldown_enable <= reg_req_i.wdata[IOVP_POS_PULLDOWN_EN];
        bus_overvoltage_threshold <=
            reg_req_i.wdata[IOVP_POS_BUS_THR_HI:IOVP_POS_BUS_THR_LO];
      end
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= reg_req_i.rd;
    end
  end

  assign reg_rdata_o = rdata;
  assign reg_rvalid_o = rvalid;
  // Level interrupt while an unmasked flag is pending
  assign irq_o = input_ovp_event_flag && !input_ovp_irq_mask;
  // Gate drive needs no condition and no pulldown request; the pump state does not enter it
  assign power_ctl_o.external_fet_gate_drive =
      !input_ovp_live_status && !bus_pulldown_enable;
  assign power_ctl_o.bus_pulldown = bus_pulldown_enable || !cp_sync;
  assign power_ctl_o.blocking_switch = !bus_overvoltage_config_live;
  assign power_ctl_o.charge_enable_force_off = bus_overvoltage_config_live;
  assign external_input_ovp_threshold_mv_o = ext_thr_mv;
  assign bus_overvoltage_threshold_mv_o = bus_thr_mv;

  // Checks
  AST_STATUS_TRACKS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_supply_node_mv_i >= ext_thr_mv) |=> input_ovp_live_status)
    else $error("live status missed the overvoltage");
  AST_STATUS_ENDS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_supply_node_mv_i < ext_thr_mv) |=> !input_ovp_live_status)
    else $error("live status stuck after condition ended");
  AST_FLAG_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ($rose(input_ovp_live_status) && !reg_soft_rst_i) |=> input_ovp_event_flag)
    else $error("event flag not set on overvoltage");
  AST_FLAG_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (rd_fet && !input_ovp_event) |=> !input_ovp_event_flag)
    else $error("event flag not cleared by read");
  AST_MASK_BLOCKS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    input_ovp_irq_mask |-> !irq_o)
    else $error("masked event raised interrupt");
  AST_IRQ_RAISE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ($rose(input_ovp_live_status) && !input_ovp_irq_mask && !reg_soft_rst_i && !wr_fet)
    |=> irq_o)
    else $error("unmasked event raised no interrupt");
  AST_EXT_LINEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (external_input_ovp_threshold == 3'h2) |-> (ext_thr_mv == 16'h32c8))
    else $error("input threshold formula wrong");
  AST_EXT_SPECIAL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (external_input_ovp_threshold == 3'h7) |-> (ext_thr_mv == 16'h1964))
    else $error("all ones code did not give 6.5 V");
  AST_GATE_OFF: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_supply_node_mv_i >= ext_thr_mv) |=> !power_ctl_o.external_fet_gate_drive)
    else $error("gate drive stayed on above threshold");
  AST_PULLDOWN_EN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    bus_pulldown_enable |-> (power_ctl_o.bus_pulldown
                             && !power_ctl_o.external_fet_gate_drive))
    else $error("pulldown enable not honoured");
  AST_PUMP_STOPPED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!charge_pump_running_i)[*3] |-> power_ctl_o.bus_pulldown)
    else $error("pulldown inactive with pump stopped");
  AST_BUS_DEFAULT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_overvoltage_threshold == 7'h3a) |-> (bus_thr_mv == 16'h2292))
    else $error("bus threshold reset code wrong");
  AST_BUS_TRIP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_supply_node_mv_i >= bus_thr_mv) |=> (!power_ctl_o.blocking_switch
                                              && power_ctl_o.charge_enable_force_off))
    else $error("bus overvoltage did not open switch");
  AST_RSVD_READ: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_fet |=> (reg_rdata_o[IOVP_POS_RSVD_HI:IOVP_POS_RSVD_LO] == IOVP_RSVD_READ))
    else $error("reserved bits read wrong");
  AST_SOFT_RST: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_soft_rst_i |=> (external_input_ovp_threshold == 3'h3
                        && bus_overvoltage_threshold == 7'h3a
                        && !bus_pulldown_enable && !input_ovp_irq_mask))
    else $error("soft reset did not restore fields");
  // Flag only moves on an event, a read or a soft reset
  AST_FLAG_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (input_ovp_event_flag && !rd_fet && !reg_soft_rst_i) |=> input_ovp_event_flag)
    else $error("event flag lost without a read");
  AST_FLAG_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!input_ovp_event_flag && !input_ovp_event) |=> !input_ovp_event_flag)
    else $error("event flag set without an event");
  AST_FLAG_MASKED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ($rose(input_ovp_live_status) && input_ovp_irq_mask && !reg_soft_rst_i)
    |=> input_ovp_event_flag)
    else $error("masked event not recorded in flag");
  AST_IRQ_CLEARED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (rd_fet && !input_ovp_event) |=> !irq_o)
    else $error("interrupt stayed up after read");
  AST_GATE_ON: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_supply_node_mv_i < ext_thr_mv && !bus_pulldown_enable && !wr_bus)
    |=> power_ctl_o.external_fet_gate_drive)
    else $error("gate drive off below threshold");
  AST_EXT_SPECIAL_TRIP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (external_input_ovp_threshold == IOVP_EXT_SPECIAL_CODE
     && bus_supply_node_mv_i >= IOVP_EXT_SPECIAL_MV) |=> input_ovp_live_status)
    else $error("all ones code did not trip at 6.5 V");
  AST_BUS_CLOSED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_supply_node_mv_i < bus_thr_mv) |=> (power_ctl_o.blocking_switch
                                             && !power_ctl_o.charge_enable_force_off))
    else $error("blocking switch open below bus threshold");
  // Threshold table points
  AST_BUS_BASE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_overvoltage_threshold == 7'h00) |-> (bus_thr_mv == 16'h173e))
    else $error("bus threshold base wrong");
  AST_BUS_TOP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_overvoltage_threshold == 7'h7f) |-> (bus_thr_mv == 16'h300c))
    else $error("bus threshold top code wrong");
  AST_EXT_BASE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (external_input_ovp_threshold == 3'h0) |-> (ext_thr_mv == 16'h2af8))
    else $error("input threshold base wrong");
  AST_EXT_TOP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (external_input_ovp_threshold == 3'h6) |-> (ext_thr_mv == 16'h4268))
    else $error("input threshold top linear code wrong");
  // Write, hold and read-back behaviour, pump pulldown and soft reset of the flag
  AST_WRITE_MASK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_fet && !reg_soft_rst_i) |=> (input_ovp_irq_mask == $past(wdata_irq_mask)))
    else $error("mask write not taken");
  AST_WRITE_EXT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_fet && !reg_soft_rst_i) |=> (external_input_ovp_threshold == $past(wdata_ext_thr)))
    else $error("input threshold write not taken");
  AST_WRITE_BUS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_bus && !reg_soft_rst_i) |=> (bus_overvoltage_threshold == $past(wdata_bus_thr)))
    else $error("bus threshold write not taken");
  AST_WRITE_PD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_bus && !reg_soft_rst_i) |=> (bus_pulldown_enable == $past(wdata_pd_en)))
    else $error("pulldown enable write not taken");
  AST_FET_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!wr_fet && !reg_soft_rst_i)
    |=> ($stable(input_ovp_irq_mask) && $stable(external_input_ovp_threshold)))
    else $error("first register field changed without a write");
  AST_BUS_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!wr_bus && !reg_soft_rst_i)
    |=> ($stable(bus_pulldown_enable) && $stable(bus_overvoltage_threshold)))
    else $error("second register field changed without a write");
  AST_STATUS_READ: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_fet |=> (reg_rdata_o[IOVP_POS_LIVE_STATUS] == $past(input_ovp_live_status)))
    else $error("live status read back wrong");
  AST_FLAG_READ: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_fet |=> (reg_rdata_o[IOVP_POS_EVENT_FLAG] == $past(input_ovp_event_flag)))
    else $error("event flag read back wrong");
  AST_PUMP_RUNNING: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (charge_pump_running_i[*3] ##0 !bus_pulldown_enable) |-> !power_ctl_o.bus_pulldown)
    else $error("pulldown active with pump running");
  AST_SOFT_FLAG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_soft_rst_i |=> (!input_ovp_event_flag && !irq_o))
    else $error("soft reset left flag or interrupt set");
endmodule
`default_nettype wire

//--- verif/iovp_host_model.sv
// Host controller model: register strobes and adapter voltage source
`default_nettype none
module iovp_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Register port
  output iovp_pkg::iovp_reg_req_t reg_req_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  // Adapter voltage in mV
  output logic [15:0] bus_mv_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import iovp_pkg::*;
  initial begin
    reg_req_o = '0;
    bus_mv_o = 16'h1388;
  end
  // Strobe stands for one taking edge; answer is taken just after that same edge
  task automatic access(input logic rd, input logic wr, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge sys_clk_i);
    #1;
    reg_req_o = '{rd: rd, wr: wr, addr: a, wdata: d};
    @(posedge sys_clk_i);
    #1;
    reg_req_o = '0;
    q = reg_rdata_i;
    v = reg_rvalid_i;
  endtask
  // Overvoltage only on command; otherwise held under the thresholds
  task automatic set_mv(input logic [15:0] mv);
    bus_mv_o = mv;
  endtask
endmodule
`default_nettype wire

//--- verif/iovp_regs_bench.sv
// Self-checking bench for the input overvoltage protection registers
`default_nettype none
module iovp_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import iovp_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic soft_rst = 1'b0;
  logic pump_run = 1'b1;
  iovp_reg_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic [15:0] bus_mv;
  logic irq;
  iovp_power_ctl_t pc;
  logic [15:0] ext_thr;
  logic [15:0] bus_thr;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  iovp_regs iovp_regs_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_soft_rst_i(soft_rst),
    .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .bus_supply_node_mv_i(bus_mv), .charge_pump_running_i(pump_run), .irq_o(irq),
    .power_ctl_o(pc), .external_input_ovp_threshold_mv_o(ext_thr),
    .bus_overvoltage_threshold_mv_o(bus_thr));
  iovp_host_model iovp_host_model_i (.sys_clk_i(sys_clk_i), .reg_req_o(req),
    .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .bus_mv_o(bus_mv));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic v;
    iovp_host_model_i.access(1'b0, 1'b1, a, d, q, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic v;
    iovp_host_model_i.access(1'b1, 1'b0, a, 8'h00, q, v);
    chk("rvalid", 16'h0001, {15'h0000, v});
    chk("rdata", {8'h00, e}, {8'h00, q});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic t_reset;
    chk("ext_thr", 16'h36b0, ext_thr);
    chk("bus_thr", 16'h2292, bus_thr);
    rd(8'h05, 8'h03);
    rd(8'h06, 8'h3a);
    $display("t_reset done");
  endtask
  task automatic t_codes;
    for (int c = 0; c < 8; c++) begin
      wr(8'h05, 8'(c));
      chk("ext_thr", (c == 7) ? 16'h1964 : 16'h2af8 + 16'(c) * 16'h03e8, ext_thr);
    end
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h27);
    wr(8'h06, 8'h00);
    chk("bus_thr", 16'h173e, bus_thr);
    wr(8'h06, 8'h7f);
    chk("bus_thr", 16'h300c, bus_thr);
    $display("t_codes done");
  endtask
  task automatic t_ovp;
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h3a);
    iovp_host_model_i.set_mv(16'h2af7);
    wt(4);
    rd(8'h05, 8'h00);
    chk("gate", 16'h0001, {15'h0000, pc.external_fet_gate_drive});
    chk("blocking", 16'h0000, {15'h0000, pc.blocking_switch});
    iovp_host_model_i.set_mv(16'h2af8);
    wt(4);
    chk("irq", 16'h0001, {15'h0000, irq});
    chk("gate", 16'h0000, {15'h0000, pc.external_fet_gate_drive});
    chk("blocking", 16'h0000, {15'h0000, pc.blocking_switch});
    chk("force_off", 16'h0001, {15'h0000, pc.charge_enable_force_off});
    rd(8'h05, 8'hc0);
    rd(8'h05, 8'h80);
    iovp_host_model_i.set_mv(16'h1388);
    wt(3);
    rd(8'h05, 8'h00);
    chk("irq", 16'h0000, {15'h0000, irq});
    chk("blocking", 16'h0001, {15'h0000, pc.blocking_switch});
    chk("force_off", 16'h0000, {15'h0000, pc.charge_enable_force_off});
    chk("gate", 16'h0001, {15'h0000, pc.external_fet_gate_drive});
    wr(8'h05, 8'h07);
    iovp_host_model_i.set_mv(16'h1964);
    wt(4);
    chk("gate", 16'h0000, {15'h0000, pc.external_fet_gate_drive});
    chk("blocking", 16'h0001, {15'h0000, pc.blocking_switch});
    rd(8'h05, 8'hc7);
    iovp_host_model_i.set_mv(16'h1388);
    wt(3);
    rd(8'h05, 8'h07);
    wr(8'h05, 8'h20);
    iovp_host_model_i.set_mv(16'h2af8);
    wt(4);
    chk("irq", 16'h0000, {15'h0000, irq});
    rd(8'h05, 8'he0);
    iovp_host_model_i.set_mv(16'h1388);
    wt(3);
    $display("t_ovp done");
  endtask
  task automatic t_pull;
    chk("pulldown", 16'h0000, {15'h0000, pc.bus_pulldown});
    wr(8'h06, 8'hba);
    chk("pulldown", 16'h0001, {15'h0000, pc.bus_pulldown});
    chk("gate", 16'h0000, {15'h0000, pc.external_fet_gate_drive});
    wr(8'h06, 8'h3a);
    pump_run = 1'b0;
    wt(3);
    chk("pulldown", 16'h0001, {15'h0000, pc.bus_pulldown});
    pump_run = 1'b1;
    wt(3);
    chk("pulldown", 16'h0000, {15'h0000, pc.bus_pulldown});
    $display("t_pull done");
  endtask
  task automatic t_soft;
    wr(8'h05, 8'h24);
    wr(8'h06, 8'hff);
    wr(8'h07, 8'h55);
    rd(8'h07, 8'h00);
    rd(8'h05, 8'h24);
    soft_rst = 1'b1;
    wt(1);
    soft_rst = 1'b0;
    rd(8'h05, 8'h03);
    rd(8'h06, 8'h3a);
    $display("t_soft done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Whole run is about 120 cycles; ceiling leaves ample margin
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_codes();
    t_ovp();
    t_pull();
    t_soft();
    stop_test();
  end
endmodule
`default_nettype wire
